// ===== hdl/flash_guard_pkg.sv
package flash_guard_pkg;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [31:0] PE_WRITE_GUARD_ADDR        = 32'h0008c296;
   localparam logic [31:0] ACCESS_STATUS_ADDR         = 32'h007fe010;
   localparam logic [31:0] ACCESS_ERROR_IRQ_EN_ADDR   = 32'h007fe014;
   localparam logic [31:0] READY_IRQ_ENABLE_ADDR      = 32'h007fe018;
   localparam logic [31:0] CMD_START_ADDRESS_ADDR     = 32'h007fe030;
   localparam logic [31:0] CMD_END_ADDRESS_ADDR       = 32'h007fe034;
   localparam logic [31:0] FIRMWARE_RAM_ENABLE_ADDR   = 32'h007fe054;
   localparam logic [31:0] SEQUENCER_STATUS_ADDR      = 32'h007fe080;
   localparam logic [31:0] PE_MODE_ENTRY_ADDR         = 32'h007fe084;
   localparam logic [31:0] PROTECTION_CONTROL_ADDR    = 32'h007fe088;
   localparam logic [31:0] SETUP_INITIALIZE_ADDR      = 32'h007fe08c;
   localparam logic [31:0] LOCK_BIT_STATUS_ADDR       = 32'h007fe090;
   localparam logic [31:0] COMMAND_ISSUE_ADDR         = 32'h007fe0a0;
   localparam logic [31:0] PE_ERROR_STATUS_ADDR       = 32'h007fe0c0;
   localparam logic [31:0] BLANK_CHECK_CONTROL_ADDR   = 32'h007fe0d0;
   localparam logic [31:0] BLANK_CHECK_STATUS_ADDR    = 32'h007fe0d4;
   localparam logic [31:0] PROGRAM_START_ADDRESS_ADDR = 32'h007fe0d8;
   localparam logic [31:0] PROCESSING_SWITCH_ADDR     = 32'h007fe0e0;
   localparam logic [31:0] PROCESSING_CLOCK_ADDR      = 32'h007fe0e4;
   localparam logic [31:0] SEQ_REGION_FIRST_ADDR      = 32'h007fe010;
   localparam logic [31:0] SEQ_REGION_LAST_ADDR       = 32'h007fe0e4;

   // ************************************************************
   // field positions and values after reset
   // ************************************************************
   localparam int          CORR_BIT          = 0;   // correction flag
   localparam int          DATA_VIOL_BIT     = 3;   // data violation
   localparam int          LOCK_FLAG_BIT     = 4;   // command lock
   localparam int          CODE_VIOL_BIT     = 7;   // code violation
   localparam int          STAT_MONITOR_BIT  = 0;
   localparam int          STAT_ILLEGAL_BIT  = 14;
   localparam int          STAT_READY_BIT    = 15;
   localparam logic [7:0]  STATUS_USED_MASK  = 8'h99;
   localparam logic [1:0]  PE_ENABLE_VALUE   = 2'h1;
   localparam logic [7:0]  GUARD_RESET       = 8'h00;
   localparam logic [7:0]  STATUS_RESET      = 8'h00;
   localparam logic [7:0]  ERR_IRQ_EN_RESET  = 8'h99;
   localparam logic [7:0]  READY_IRQ_RESET   = 8'h00;
   localparam logic [31:0] ADDR_REG_RESET    = 32'h00000000;
   localparam logic [31:0] ADDR_RO_MASK      = 32'hfffffffc;

   // ************************************************************
   // address windows checked at command issue
   // ************************************************************
   localparam logic [18:0] DATA_RSVD_LO      = 19'h10000;
   localparam logic [18:0] DATA_RSVD_HI      = 19'h7ffff;
   localparam logic [18:0] CFG_LOW_HI        = 19'h0003f;
   localparam logic [18:0] CFG_HIGH_LO       = 19'h00100;
   localparam logic [23:0] CODE_RSVD_HI      = 24'hbfffff;

   // ************************************************************
   // command codes and flash modes seen from the engine
   // ************************************************************
   typedef enum logic [2:0] {
      CMD_PROGRAM      = 3'h0,
      CMD_BLOCK_ERASE  = 3'h1,
      CMD_BLANK_CHECK  = 3'h2,
      CMD_LOCK_PROGRAM = 3'h3,
      CMD_STATUS_CLEAR = 3'h4,
      CMD_FORCED_STOP  = 3'h5,
      CMD_CONFIG_SET   = 3'h6,
      CMD_OTHER        = 3'h7
   } command_e;

   typedef enum logic [1:0] {
      MODE_READ = 2'h0,
      MODE_CODE = 2'h1,
      MODE_DATA = 2'h2
   } flash_mode_e;

endpackage

// ===== hdl/flash_pe_guard.sv
// Overview of operation
// - guard field 01 alone permits program, erase, blank check, lock program
// - unused guard and status bits read zero; software writes zero there
// - guard register resets on any reset and on either standby entry
// - single-bit fix on firmware RAM or parameter read sets correction flag
// - double-bit firmware RAM error sets lock flag, correction flag unchanged
// - forced stop start clears correction flag when monitor flag is set
// - violation flags clear only by writing zero after one was read
// - either violation flag also sets the command lock flag
// - either violation flag also sets the illegal command error
// - lock clears on status clear or forced stop with no violations
// - any protection error detected by the engine sets the lock flag
// - data mode command at start 1_0000h..7_FFFFh flags data violation
// - data mode config set outside 0_0040h..0_00FFh flags data violation
// - code mode command at start address up to BF_FFFFh flags code violation
// - registers decode at their listed addresses with their listed widths
// - each error flag raises the error interrupt only when enabled
// - start address writes ignored while busy; its two low bits read only
`timescale 1ns/100ps

module flash_pe_guard
   import flash_guard_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // register port from the host processor
   input  wire logic [31:0] regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [31:0] regWdata,
   output logic      [31:0] regRdata,
   output logic             regRvalid,
   // events from the flash control engine
   input  wire logic        cmdStart,
   input  wire logic [2:0]  cmdCode,
   input  wire logic [1:0]  flashMode,
   input  wire logic        singleBitCorrected,
   input  wire logic        doubleBitError,
   input  wire logic        protectionError,
   input  wire logic        correctionMonitorFlag,
   input  wire logic        sequencerReadyFlag,
   // power management
   input  wire logic        standbyEntry,
   // results towards the engine and the interrupt controller
   output logic             cmdPermitted,
   output logic             cmdRefused,
   output logic             commandLockedFlag,
   output logic             illegalCommandError,
   output logic             accessErrorIrq
);

   // ************************************************************
   // storage
   // ************************************************************
   logic [7:0]  guard_r;
   logic [7:0]  status_r;
   logic [7:0]  errIrqEn_r;
   logic [7:0]  readyIrqEn_r;
   logic [31:0] startAddr_r;
   logic [31:0] endAddr_r;
   logic        illegal_r;
   logic [1:0]  violRead_r;    // {code, data} seen as one by a read

   // ************************************************************
   // address decode
   // ************************************************************
   logic hitGuard;
   logic hitStatus;
   logic hitErrEn;
   logic hitRdyEn;
   logic hitStart;
   logic hitEnd;
   logic hitSeqStat;
   logic hitSeqRegion;

   // decode map
   // full compare; partial decode would alias the guard byte
   assign hitGuard     = (regAddr == PE_WRITE_GUARD_ADDR);
   assign hitStatus    = (regAddr == ACCESS_STATUS_ADDR);
   assign hitErrEn     = (regAddr == ACCESS_ERROR_IRQ_EN_ADDR);
   assign hitRdyEn     = (regAddr == READY_IRQ_ENABLE_ADDR);
   assign hitStart     = (regAddr == CMD_START_ADDRESS_ADDR);
   assign hitEnd       = (regAddr == CMD_END_ADDRESS_ADDR);
   assign hitSeqStat   = (regAddr == SEQUENCER_STATUS_ADDR);
   assign hitSeqRegion = (regAddr >= SEQ_REGION_FIRST_ADDR) &&
                         (regAddr <= SEQ_REGION_LAST_ADDR);

   // ************************************************************
   // command checks
   // ************************************************************
   logic [18:0] dataOfs;
   logic [23:0] codeOfs;
   logic        isPeCmd;
   logic        isClearCmd;
   logic        guardOpen;
   logic        dataViol;
   logic        codeViol;
   logic        newViol;

   assign dataOfs = startAddr_r[18:0];
   assign codeOfs = startAddr_r[23:0];

   // commands that the guard field gates
   assign isPeCmd = (cmdCode == CMD_PROGRAM) ||
                    (cmdCode == CMD_BLOCK_ERASE) ||
                    (cmdCode == CMD_BLANK_CHECK) ||
                    (cmdCode == CMD_LOCK_PROGRAM);

   // the two commands that may lift the lock
   assign isClearCmd = (cmdCode == CMD_STATUS_CLEAR) ||
                       (cmdCode == CMD_FORCED_STOP);

   assign guardOpen = (guard_r[1:0] == PE_ENABLE_VALUE);

   // data area windows
   // only the low 19 address bits count in data mode
   always_comb begin
      dataViol = 1'b0;
      if (cmdStart && (flashMode == MODE_DATA)) begin
         if (cmdCode == CMD_CONFIG_SET) begin
            dataViol = (dataOfs <= CFG_LOW_HI) ||
                       (dataOfs >= CFG_HIGH_LO);
         end else begin
            dataViol = (dataOfs >= DATA_RSVD_LO) &&
                       (dataOfs <= DATA_RSVD_HI);
         end
      end
   end

   // code area window
   // the top byte is ignored in code mode
   assign codeViol = cmdStart && (flashMode == MODE_CODE) &&
                     (codeOfs <= CODE_RSVD_HI);

   assign newViol = dataViol || codeViol;

   // ************************************************************
   // command outcome
   // ************************************************************
   logic refuse;

   // a locked engine or a closed guard turns the command away
   // clear commands always pass: the only way out of the lock
   assign refuse = commandLockedFlag || newViol ||
                   (isPeCmd && !guardOpen && !isClearCmd);

   // permit or refuse
   // one pulse per command, never both
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmdPermitted <= 1'b0;
         cmdRefused   <= 1'b0;
      end else begin
         cmdPermitted <= cmdStart && (isClearCmd || !refuse);
         cmdRefused   <= cmdStart && !isClearCmd && refuse;
      end
   end

   // ************************************************************
   // guard register
   // ************************************************************
   // reset and standby entry reload
   // standby beats a write, so the guard always comes back closed
   always_ff @(posedge clk) begin
      if (!rstn || standbyEntry) begin
         guard_r <= GUARD_RESET;
      end else if (regWrite && hitGuard) begin
         guard_r <= {6'h00, regWdata[1:0]};
      end
   end

   // ************************************************************
   // access status flags
   // ************************************************************
   logic wrStatus;
   logic rdStatus;
   logic clrData;
   logic clrCode;
   logic lockRelease;
   logic eccClear;

   assign wrStatus = regWrite && hitStatus;
   assign rdStatus = regRead && hitStatus;

   // zero written only after a one was read
   // a blind zero must not wipe an unseen violation
   assign clrData = wrStatus && !regWdata[DATA_VIOL_BIT] && violRead_r[0];
   assign clrCode = wrStatus && !regWdata[CODE_VIOL_BIT] && violRead_r[1];

   // both violations zero when the clear command starts
   // flags as they stood before this edge count
   assign lockRelease = cmdStart && isClearCmd &&
                        !status_r[DATA_VIOL_BIT] &&
                        !status_r[CODE_VIOL_BIT];

   assign eccClear = cmdStart && (cmdCode == CMD_FORCED_STOP) &&
                     correctionMonitorFlag;

   // remember a read of one so that a later zero may clear
   // the mark falls with its flag: a new violation needs a new read
   always_ff @(posedge clk) begin
      if (!rstn) begin
         violRead_r <= 2'b00;
      end else begin
         if (!status_r[DATA_VIOL_BIT] || clrData) begin
            violRead_r[0] <= 1'b0;
         end else if (rdStatus) begin
            violRead_r[0] <= 1'b1;
         end
         if (!status_r[CODE_VIOL_BIT] || clrCode) begin
            violRead_r[1] <= 1'b0;
         end else if (rdStatus) begin
            violRead_r[1] <= 1'b1;
         end
      end
   end

   // flags reset to zero; a set in the clear cycle wins
   // reserved bits are rewritten to zero every cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         status_r <= STATUS_RESET;
      end else begin
         // correction flag
         // set beats the forced stop clear
         if (singleBitCorrected) begin
            status_r[CORR_BIT] <= 1'b1;
         end else if (eccClear) begin
            status_r[CORR_BIT] <= 1'b0;
         end
         if (dataViol) begin
            status_r[DATA_VIOL_BIT] <= 1'b1;
         end else if (clrData) begin
            status_r[DATA_VIOL_BIT] <= 1'b0;
         end
         if (codeViol) begin
            status_r[CODE_VIOL_BIT] <= 1'b1;
         end else if (clrCode) begin
            status_r[CODE_VIOL_BIT] <= 1'b0;
         end
         // lock set, release
         // a double-bit error leaves the correction flag alone
         // a new error in the release cycle keeps the lock
         if (newViol || doubleBitError || protectionError) begin
            status_r[LOCK_FLAG_BIT] <= 1'b1;
         end else if (lockRelease) begin
            status_r[LOCK_FLAG_BIT] <= 1'b0;
         end
         status_r[2:1] <= 2'b00;
         status_r[6:5] <= 2'b00;
      end
   end

   // illegal command error follows the violations
   always_ff @(posedge clk) begin
      if (!rstn) begin
         illegal_r <= 1'b0;
      end else if (newViol) begin
         illegal_r <= 1'b1;
      end else if (lockRelease) begin
         illegal_r <= 1'b0;
      end
   end

   // lock and error outputs mirror the flags one for one
   // both are flops, so the engine sees no decode glitch
   assign commandLockedFlag   = status_r[LOCK_FLAG_BIT];
   assign illegalCommandError = illegal_r;

   // ************************************************************
   // interrupt enables and address registers
   // ************************************************************
   // enables keep only the defined bits
   always_ff @(posedge clk) begin
      if (!rstn) begin
         errIrqEn_r   <= ERR_IRQ_EN_RESET;
         readyIrqEn_r <= READY_IRQ_RESET;
      end else begin
         if (regWrite && hitErrEn) begin
            errIrqEn_r <= regWdata[7:0] & STATUS_USED_MASK;
         end
         if (regWrite && hitRdyEn) begin
            readyIrqEn_r <= {7'h00, regWdata[0]};
         end
      end
   end

   // writes only while ready; low two bits read only
   // a busy engine still uses the address, so writes drop
   always_ff @(posedge clk) begin
      if (!rstn) begin
         startAddr_r <= ADDR_REG_RESET;
         endAddr_r   <= ADDR_REG_RESET;
      end else if (regWrite && sequencerReadyFlag) begin
         if (hitStart) begin
            startAddr_r <= regWdata & ADDR_RO_MASK;
         end
         if (hitEnd) begin
            endAddr_r <= regWdata & ADDR_RO_MASK;
         end
      end
   end

   // enabled flags drive the error interrupt
   // one cycle behind the flags, for a flop-driven output
   always_ff @(posedge clk) begin
      if (!rstn) begin
         accessErrorIrq <= 1'b0;
      end else begin
         accessErrorIrq <= |(status_r & errIrqEn_r & STATUS_USED_MASK);
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   logic [31:0] rdMux;
   logic [31:0] seqStatus;

   // live view of the engine state for software
   // the other status bits belong to the engine, not here
   always_comb begin
      seqStatus = 32'h00000000;
      seqStatus[STAT_MONITOR_BIT] = correctionMonitorFlag;
      seqStatus[STAT_ILLEGAL_BIT] = illegal_r;
      seqStatus[STAT_READY_BIT]   = sequencerReadyFlag;
   end

   // mapped but not held here reads zero, as does unmapped space
   always_comb begin
      rdMux = 32'h00000000;
      if (hitGuard) begin
         rdMux = {24'h000000, guard_r};
      end else if (hitStatus) begin
         rdMux = {24'h000000, status_r};
      end else if (hitErrEn) begin
         rdMux = {24'h000000, errIrqEn_r};
      end else if (hitRdyEn) begin
         rdMux = {24'h000000, readyIrqEn_r};
      end else if (hitStart) begin
         rdMux = startAddr_r;
      end else if (hitEnd) begin
         rdMux = endAddr_r;
      end else if (hitSeqStat) begin
         rdMux = seqStatus;
      end else if (hitSeqRegion) begin
         rdMux = 32'h00000000;
      end
   end

   // answer registered one cycle after the strobe
   // data is held between reads for a slow host
   always_ff @(posedge clk) begin
      if (!rstn) begin
         regRdata  <= 32'h00000000;
         regRvalid <= 1'b0;
      end else begin
         regRvalid <= regRead;
         if (regRead) begin
            regRdata <= rdMux;
         end
      end
   end

endmodule

// ===== verif/flash_host_model.sv
`timescale 1ns/100ps

// ************************************************
// host processor on the peripheral register port
// ************************************************
module flash_host_model (
   // clock
   input  wire logic        clk,
   // requests
   output logic      [31:0] regAddr,
   output logic             regWrite,
   output logic             regRead,
   output logic      [31:0] regWdata,
   // answer
   input  wire logic [31:0] regRdata
);
   initial begin
      regAddr  = 32'h0;
      regWrite = 1'b0;
      regRead  = 1'b0;
      regWdata = 32'h0;
   end

   // released lines show the inverse so stale values cannot pass
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      regAddr  <= ~a;
      regWdata <= ~d;
   endtask

   // data is registered at the edge that takes the strobe
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      #1 d = regRdata;
   endtask
endmodule

// ===== verif/flash_pe_guard_properties.sv
`timescale 1ns/100ps

// ************************************************
// port checker for the guard and status front end
// ************************************************
module flash_pe_guard_properties (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // host port and engine events
   input  wire logic       regRead,
   input  wire logic       regRvalid,
   input  wire logic       cmdStart,
   input  wire logic [2:0] cmdCode,
   input  wire logic       doubleBitError,
   input  wire logic       protectionError,
   // results
   input  wire logic       cmdPermitted,
   input  wire logic       cmdRefused,
   input  wire logic       commandLockedFlag,
   input  wire logic       illegalCommandError,
   input  wire logic       accessErrorIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // a read strobe is answered exactly one cycle later
   property p_rdAns; regRvalid == $past(regRead); endproperty
   a_rdAns:
      assert property (p_rdAns) else $error("read answer late or spurious");
   property p_oneAns; cmdStart |=> cmdPermitted != cmdRefused; endproperty
   a_oneAns:
      assert property (p_oneAns) else $error("command not answered once");
   property p_quiet; !cmdStart |=> !cmdPermitted && !cmdRefused; endproperty
   a_quiet:
      assert property (p_quiet) else $error("answer without command");
   property p_clrOk;
      cmdStart && cmdCode inside {3'h4, 3'h5} |=> cmdPermitted;
   endproperty
   a_clrOk:
      assert property (p_clrOk) else $error("clear command refused");
   // while locked only the two clear commands get through
   property p_lockRef;
      cmdStart && commandLockedFlag && !(cmdCode inside {3'h4, 3'h5})
         |=> cmdRefused;
   endproperty
   a_lockRef:
      assert property (p_lockRef) else $error("command accepted while locked");
   property p_lockHold; commandLockedFlag && !cmdStart |=> commandLockedFlag;
   endproperty
   a_lockHold:
      assert property (p_lockHold) else $error("lock dropped without command");
   property p_dbl; doubleBitError || protectionError |=> commandLockedFlag;
   endproperty
   a_dbl:
      assert property (p_dbl) else $error("engine error did not lock");
   property p_ill; illegalCommandError |-> commandLockedFlag; endproperty
   a_ill:
      assert property (p_ill) else $error("illegal error without lock");
   property p_rst;
      $rose(rstn) |-> !commandLockedFlag && !illegalCommandError
         && !accessErrorIrq;
   endproperty
   a_rst:
      assert property (p_rst) else $error("flags not clear after reset");
endmodule

// ===== verif/flash_pe_guard_tb_top.sv
`timescale 1ns/100ps

module flash_pe_guard_tb_top
   import flash_guard_pkg::*;
;
   // ************************************************
   // signals and tables
   // ************************************************
   logic        clk, rstn, regWrite, regRead, regRvalid, cmdStart;
   logic        correctionMonitorFlag, sequencerReadyFlag, standbyEntry;
   logic        cmdPermitted, cmdRefused, commandLockedFlag;
   logic        illegalCommandError, accessErrorIrq;
   logic [31:0] regAddr, regWdata, regRdata, rdv, expv;
   logic [2:0]  cmdCode, ev;
   logic [1:0]  flashMode;
   int          failures, n_tests;
   int          cyc = 0;
   localparam int          ACODE [9] = '{0, 0, 0, 6, 6, 6, 6, 0, 0};
   localparam int          AMODE [9] = '{2, 2, 2, 2, 2, 2, 2, 1, 1};
   localparam int          AVIOL [9] = '{1, 0, 1, 1, 0, 0, 1, 1, 0};
   localparam logic [31:0] AADDR [9] = '{32'h10000, 32'h0fffc, 32'h7fffc,
      32'h30, 32'h40, 32'hf0, 32'h100, 32'hbffffc, 32'hc00000};

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   flash_host_model host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));

   flash_pe_guard dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
      .regRdata(regRdata), .regRvalid(regRvalid), .cmdStart(cmdStart),
      .cmdCode(cmdCode), .flashMode(flashMode),
      .singleBitCorrected(ev[0]), .doubleBitError(ev[1]),
      .protectionError(ev[2]), .correctionMonitorFlag(correctionMonitorFlag),
      .sequencerReadyFlag(sequencerReadyFlag), .standbyEntry(standbyEntry),
      .cmdPermitted(cmdPermitted), .cmdRefused(cmdRefused),
      .commandLockedFlag(commandLockedFlag),
      .illegalCommandError(illegalCommandError),
      .accessErrorIrq(accessErrorIrq));

   // ************************************************
   // shared tasks
   // ************************************************
   task automatic chk(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic rchk(input string n, input logic [31:0] a, e);
      host.rd(a, rdv);
      chk(n, rdv, e);
   endtask

   // answer pulse is judged in the single cycle it stands
   task automatic cmd(input logic [2:0] c, input logic [1:0] m,
      input logic ok);
      @(posedge clk);
      cmdStart  <= 1'b1;
      cmdCode   <= c;
      flashMode <= m;
      @(posedge clk);
      cmdStart  <= 1'b0;
      cmdCode   <= ~c;
      #1 chk("permitted", 32'(cmdPermitted), 32'(ok));
      chk("refused", 32'(cmdRefused), 32'(!ok));
   endtask

   task automatic pulse(input logic [2:0] v, input logic s);
      @(posedge clk);
      ev           <= v;
      standbyEntry <= s;
      @(posedge clk);
      ev           <= 3'h0;
      standbyEntry <= 1'b0;
   endtask

   // software side of leaving the locked state
   // read mode, so the stale start address is not checked again
   task automatic unlock();
      host.rd(ACCESS_STATUS_ADDR, rdv);
      host.wr(ACCESS_STATUS_ADDR, 32'h0);
      cmd(CMD_STATUS_CLEAR, MODE_READ, 1'b1);
   endtask

   task automatic results();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_reset();
      rchk("guard", PE_WRITE_GUARD_ADDR, 32'(GUARD_RESET));
      rchk("status", ACCESS_STATUS_ADDR, 32'h0);
      rchk("irq en", ACCESS_ERROR_IRQ_EN_ADDR, 32'(ERR_IRQ_EN_RESET));
      rchk("unmapped", 32'h007fe01c, 32'h0);
      host.wr(ACCESS_STATUS_ADDR, 32'hff);
      rchk("ones", ACCESS_STATUS_ADDR, 32'h0);
   endtask

   task automatic t_guard();
      host.wr(CMD_START_ADDRESS_ADDR, 32'hc00003);
      rchk("low bits", CMD_START_ADDRESS_ADDR, 32'hc00000);
      for (int g = 0; g < 4; g++) begin
         host.wr(PE_WRITE_GUARD_ADDR, 32'hfc | 32'(g));
         rchk("guard", PE_WRITE_GUARD_ADDR, 32'(g));
         for (int c = 0; c < 4; c++) begin
            cmd(3'(c), MODE_CODE, g == 1);
            cmd(CMD_STATUS_CLEAR, MODE_CODE, 1'b1);
         end
      end
      pulse(3'h0, 1'b1);
      rchk("standby", PE_WRITE_GUARD_ADDR, 32'(GUARD_RESET));
      host.wr(PE_WRITE_GUARD_ADDR, 32'h1);
   endtask

   task automatic t_areas();
      for (int i = 0; i < 9; i++) begin
         host.wr(CMD_START_ADDRESS_ADDR, AADDR[i]);
         cmd(3'(ACODE[i]), 2'(AMODE[i]), AVIOL[i] == 0);
         expv = !AVIOL[i] ? 32'h0 : AMODE[i] == MODE_DATA ? 32'h18 : 32'h90;
         rchk("area", ACCESS_STATUS_ADDR, expv);
         chk("illegal", 32'(illegalCommandError), 32'(AVIOL[i]));
         if (AVIOL[i] != 0) unlock();
      end
      host.wr(CMD_START_ADDRESS_ADDR, 32'h0);
      cmd(CMD_PROGRAM, MODE_CODE, 1'b0);
      host.wr(ACCESS_STATUS_ADDR, 32'h0);
      rchk("unread", ACCESS_STATUS_ADDR, 32'h90);
      chk("irq", 32'(accessErrorIrq), 32'h1);
      host.wr(ACCESS_STATUS_ADDR, 32'h0);
      rchk("held", ACCESS_STATUS_ADDR, 32'h10);
      cmd(CMD_FORCED_STOP, MODE_READ, 1'b1);
      rchk("free", ACCESS_STATUS_ADDR, 32'h0);
   endtask

   task automatic t_correct();
      host.wr(ACCESS_ERROR_IRQ_EN_ADDR, 32'h0);
      pulse(3'h1, 1'b0);
      rchk("corr", ACCESS_STATUS_ADDR, 32'h1);
      chk("masked", 32'(accessErrorIrq), 32'h0);
      host.wr(ACCESS_ERROR_IRQ_EN_ADDR, 32'h1);
      @(posedge clk);
      #1 chk("enabled", 32'(accessErrorIrq), 32'h1);
      pulse(3'h2, 1'b0);
      rchk("double", ACCESS_STATUS_ADDR, 32'h11);
      cmd(CMD_FORCED_STOP, MODE_READ, 1'b1);
      rchk("mon low", ACCESS_STATUS_ADDR, 32'h1);
      pulse(3'h4, 1'b0);
      rchk("protect", ACCESS_STATUS_ADDR, 32'h11);
      @(posedge clk) correctionMonitorFlag <= 1'b1;
      cmd(CMD_FORCED_STOP, MODE_READ, 1'b1);
      rchk("mon high", ACCESS_STATUS_ADDR, 32'h0);
      @(posedge clk) correctionMonitorFlag <= 1'b0;
   endtask

   // busy engine must not see its start address change
   task automatic t_busy();
      @(posedge clk) sequencerReadyFlag <= 1'b0;
      host.wr(CMD_START_ADDRESS_ADDR, 32'h1000);
      rchk("busy", CMD_START_ADDRESS_ADDR, 32'h0);
      @(posedge clk) sequencerReadyFlag <= 1'b1;
   endtask

   // a second reset in mid-run reloads the guard and the enables
   task automatic t_rerun();
      @(posedge clk) rstn <= 1'b0;
      @(posedge clk) rstn <= 1'b1;
      rchk("rerun", PE_WRITE_GUARD_ADDR, 32'(GUARD_RESET));
      rchk("rerun en", ACCESS_ERROR_IRQ_EN_ADDR, 32'(ERR_IRQ_EN_RESET));
   endtask

   initial begin
      rstn = 1'b0;
      cmdStart = 1'b0;
      cmdCode = 3'h0;
      flashMode = 2'h0;
      ev = 3'h0;
      standbyEntry = 1'b0;
      correctionMonitorFlag = 1'b0;
      sequencerReadyFlag = 1'b1;
      failures = 0;
      n_tests = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_guard();
      t_areas();
      t_correct();
      t_busy();
      t_rerun();
      results();
   end

   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         failures++;
         results();
      end
   end
endmodule

bind flash_pe_guard flash_pe_guard_properties chk (.clk(clk), .rstn(rstn),
   .regRead(regRead), .regRvalid(regRvalid), .cmdStart(cmdStart),
   .cmdCode(cmdCode), .doubleBitError(doubleBitError),
   .protectionError(protectionError), .cmdPermitted(cmdPermitted),
   .cmdRefused(cmdRefused), .commandLockedFlag(commandLockedFlag),
   .illegalCommandError(illegalCommandError),
   .accessErrorIrq(accessErrorIrq));
